// File: swpe_defines.svh
`ifndef SWPE_DEFINES_SVH
`define SWPE_DEFINES_SVH

// ----------------------------------------
// counter and compare values
// ----------------------------------------
`define SWPE_CNT_ZERO 16'h0000
`define SWPE_CNT_ONE 16'h0001
`define SWPE_CNT_MAX 16'hFFFF
`define SWPE_CMP_RESET 16'hFFFF
`define SWPE_BYTE_ZERO 8'h00

// ----------------------------------------
// source select bit positions
// ----------------------------------------
`define SWPE_NSRC 6
`define SWPE_NASYNC 5
`define SWPE_SRC_TMR 0
`define SWPE_SRC_ASYNC_LO 1
`define SWPE_SRC_ASYNC_HI 5

// ----------------------------------------
// event flag bit positions
// ----------------------------------------
`define SWPE_NFLAG 4
`define SWPE_FLAG_OVF 0
`define SWPE_FLAG_PR 1
`define SWPE_FLAG_PH 2
`define SWPE_FLAG_DC 3
`define SWPE_FLAGS_ZERO 4'h0

`endif

// File: swpe_far_model.sv
`timescale 1ns/1ns
`default_nettype none

// ----------------------------------------
// comparators and trigger pin
// ----------------------------------------
module swpe_far_model (
    input wire logic clk,
    input wire logic resetn,
    input wire logic [4:0] level_cmd,
    output logic external_event_input,
    output logic [3:0] comp_level
);
    // levels move only at clock edges, as the synchronizers deliver them
    always_ff @(posedge clk) begin
        if (!resetn) begin
            external_event_input <= 1'b0;
            comp_level <= 4'h0;
        end else begin
            external_event_input <= level_cmd[0];
            comp_level <= level_cmd[4:1];
        end
    end
endmodule // swpe_far_model

`default_nettype wire

// File: swpe_pkg.sv
`default_nettype none

package swpe_pkg;

    typedef enum logic [2:0] {
        SWPE_WR_PERIOD_LOW,
        SWPE_WR_PERIOD_HIGH,
        SWPE_WR_PHASE_LOW,
        SWPE_WR_PHASE_HIGH,
        SWPE_WR_DUTY_LOW,
        SWPE_WR_DUTY_HIGH
    } swpe_wsel_t;

    typedef enum logic [1:0] {
        SWPE_MOD_REG_BIT,
        SWPE_MOD_COMPARATOR,
        SWPE_MOD_CCP,
        SWPE_MOD_PIN
    } swpe_mod_t;

endpackage

`default_nettype wire

// File: swpe_src_if.sv
`timescale 1ns/1ns
`default_nettype none
`include "swpe_defines.svh"

interface swpe_src_if;
    logic [`SWPE_NASYNC-1:0] async_level;
    logic [`SWPE_NSRC-1:0] period_sel;
    logic [`SWPE_NSRC-1:0] rising_sel;
    logic [`SWPE_NSRC-1:0] falling_sel;
    logic enable;
    logic period_hit;
    logic rising_hit;
    logic falling_hit;

    modport mux (
        input async_level,
        input period_sel,
        input rising_sel,
        input falling_sel,
        input enable,
        output period_hit,
        output rising_hit,
        output falling_hit
    );

    modport core (
        output async_level,
        output period_sel,
        output rising_sel,
        output falling_sel,
        output enable,
        input period_hit,
        input rising_hit,
        input falling_hit
    );
endinterface

`default_nettype wire

// File: swpe_src_mux.sv
`timescale 1ns/1ns
`default_nettype none
`include "swpe_defines.svh"

module swpe_src_mux (
    input wire logic clk,
    input wire logic resetn,
    swpe_src_if.mux src
);

    logic [`SWPE_NASYNC-1:0] prev_level;
    logic [`SWPE_NASYNC-1:0] rise_edge;

    // ----------------------------------------
    // edge detect
    // ----------------------------------------
    // prev cleared while disabled so a level already high at enable counts once
    always_ff @(posedge clk) begin
        if (!resetn || !src.enable) begin
            prev_level <= '0;
        end else begin
            prev_level <= src.async_level;
        end
    end

    assign rise_edge = src.async_level & ~prev_level;

    function automatic logic async_hit(input logic [`SWPE_NSRC-1:0] sel,
                                       input logic [`SWPE_NASYNC-1:0] edges);
        async_hit = |(sel[`SWPE_SRC_ASYNC_HI:`SWPE_SRC_ASYNC_LO] & edges);
    endfunction

    assign src.period_hit = src.enable && async_hit(src.period_sel, rise_edge);
    assign src.rising_hit = src.enable && async_hit(src.rising_sel, rise_edge);
    assign src.falling_hit = src.enable && async_hit(src.falling_sel, rise_edge);

endmodule // swpe_src_mux

`default_nettype wire

// File: swpe_time_base.sv
// Operation
// - period event clears counter next edge, counting resumes from zero after.
// - only first rising and first falling event act in each period.
// - after a falling event, rising events are ignored until next period.
// - period event from any selected mix of match, pin, four comparators.
// - rising event from any selected mix of phase match, pin, comparators.
// - falling event from any selected mix of duty match, pin, comparators.
// - accepted rising event changes outputs.
// - accepted falling event changes outputs.
// - period, phase, duty writes apply together at first period reset after load.
// - counter is 16 bits, starts at zero, counts up each clock to FFFFh.
// - wrap from maximum without a period event sets the overflow flag.
// - counter readable as separate low and high bytes.
// - clearing enable returns counter to its reset value.
// - counter equal to buffered period makes a period event when selected.
// - counter equal to buffered period sets the period match flag.
// - period written as two bytes; comparator uses only the buffered copy.
// - selected pin or comparator levels trigger auto-shutdown without software.
// - active pulse stream gated by one selectable modulation source.
// - event flags set on each event regardless of interrupt enables.
// - disable clears event flags except the summary flag.
// - comparator and pin sources trigger on rising edge, shutdown on level.
`timescale 1ns/1ns
`default_nettype none
`include "swpe_defines.svh"

module swpe_time_base (
    input wire logic clk,
    input wire logic resetn,
    input wire logic module_enable,
    input wire logic buffered_load_request,
    input wire logic wr_en,
    input wire swpe_pkg::swpe_wsel_t wr_sel,
    input wire logic [7:0] wr_data,
    input wire logic [`SWPE_NSRC-1:0] period_source_select,
    input wire logic [`SWPE_NSRC-1:0] rising_source_select,
    input wire logic [`SWPE_NSRC-1:0] falling_source_select,
    input wire logic [`SWPE_NASYNC-2:0] shutdown_source_select,
    input wire logic shutdown_ext_select,
    input wire logic shutdown_clear,
    input wire logic external_event_input,
    input wire logic comparator_one_synced,
    input wire logic comparator_two_synced,
    input wire logic comparator_three_synced,
    input wire logic comparator_four_synced,
    input wire swpe_pkg::swpe_mod_t modulation_select,
    input wire logic modulation_reg_bit,
    input wire logic modulation_ccp,
    input wire logic modulation_pin,
    input wire logic [`SWPE_NFLAG-1:0] irq_enable,
    input wire logic [`SWPE_NFLAG-1:0] flag_clear,
    input wire logic summary_clear,
    output logic [7:0] time_base_counter_low,
    output logic [7:0] time_base_counter_high,
    output logic load_pending,
    output logic counter_overflow_flag,
    output logic period_match_flag,
    output logic phase_match_flag,
    output logic duty_match_flag,
    output logic time_base_summary_flag,
    output logic period_event,
    output logic rising_accepted,
    output logic falling_accepted,
    output logic pwm_active,
    output logic pwm_drive,
    output logic auto_shutdown
);

    swpe_src_if src ();

    logic [15:0] time_base_counter;
    logic [15:0] period_shadow;
    logic [15:0] phase_shadow;
    logic [15:0] duty_shadow;
    logic [15:0] period_value;
    logic [15:0] phase_value;
    logic [15:0] duty_value;
    logic rise_done;
    logic fall_done;
    logic pr_match;
    logic ph_match;
    logic dc_match;
    logic rising_event;
    logic falling_event;
    logic shutdown_level;
    logic modulation;
    logic [`SWPE_NFLAG-1:0] flags;
    logic [`SWPE_NFLAG-1:0] flag_set;
    logic [`SWPE_NASYNC-1:0] async_level;

    // ----------------------------------------
    // event sources
    // ----------------------------------------
    assign async_level = {comparator_four_synced, comparator_three_synced,
                          comparator_two_synced, comparator_one_synced,
                          external_event_input};
    assign src.async_level = async_level;
    assign src.period_sel = period_source_select;
    assign src.rising_sel = rising_source_select;
    assign src.falling_sel = falling_source_select;
    assign src.enable = module_enable;

    swpe_src_mux u_src_mux (
        .clk(clk),
        .resetn(resetn),
        .src(src)
    );

    assign pr_match = time_base_counter == period_value;
    assign ph_match = time_base_counter == phase_value;
    assign dc_match = time_base_counter == duty_value;

    assign period_event = module_enable && ((period_source_select[`SWPE_SRC_TMR] && pr_match)
                          || src.period_hit);
    assign rising_event = module_enable && ((rising_source_select[`SWPE_SRC_TMR] && ph_match)
                          || src.rising_hit);
    assign falling_event = module_enable && ((falling_source_select[`SWPE_SRC_TMR] && dc_match)
                           || src.falling_hit);

    // ----------------------------------------
    // once-per-period suppression
    // ----------------------------------------
    // events in the period-event cycle still belong to the closing period
    assign rising_accepted = rising_event && !rise_done && !fall_done;
    assign falling_accepted = falling_event && !fall_done;

    always_ff @(posedge clk) begin
        if (!resetn || !module_enable || period_event) begin
            rise_done <= 1'b0;
            fall_done <= 1'b0;
        end else begin
            if (rising_accepted) begin
                rise_done <= 1'b1;
            end
            if (falling_accepted) begin
                fall_done <= 1'b1;
            end
        end
    end

    // ----------------------------------------
    // active pulse and drive
    // ----------------------------------------
    // falling wins a tie so equal phase and duty gives a zero-width pulse
    always_ff @(posedge clk) begin
        if (!resetn || !module_enable) begin
            pwm_active <= 1'b0;
        end else if (falling_accepted) begin
            pwm_active <= 1'b0;
        end else if (rising_accepted) begin
            pwm_active <= 1'b1;
        end
    end

    always_comb begin
        unique case (modulation_select)
            swpe_pkg::SWPE_MOD_REG_BIT: modulation = modulation_reg_bit;
            swpe_pkg::SWPE_MOD_COMPARATOR: modulation = comparator_one_synced;
            swpe_pkg::SWPE_MOD_CCP: modulation = modulation_ccp;
            swpe_pkg::SWPE_MOD_PIN: modulation = modulation_pin;
        endcase
    end

    assign shutdown_level = (shutdown_ext_select && external_event_input)
                            || |(shutdown_source_select & async_level[`SWPE_NASYNC-1:1]);

    // level sensitive; latched so a short glitch still ends the drive
    always_ff @(posedge clk) begin
        if (!resetn || !module_enable) begin
            auto_shutdown <= 1'b0;
        end else if (shutdown_level) begin
            auto_shutdown <= 1'b1;
        end else if (shutdown_clear) begin
            auto_shutdown <= 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            pwm_drive <= 1'b0;
        end else begin
            // a fall in the rise cycle wins, so equal phase and duty never drives
            pwm_drive <= module_enable && !auto_shutdown && !shutdown_level
                         && modulation && (rising_accepted || pwm_active)
                         && !falling_accepted;
        end
    end

    // ----------------------------------------
    // time base counter
    // ----------------------------------------
    always_ff @(posedge clk) begin
        if (!resetn || !module_enable) begin
            time_base_counter <= `SWPE_CNT_ZERO;
        end else if (period_event) begin
            time_base_counter <= `SWPE_CNT_ZERO;
        end else begin
            time_base_counter <= time_base_counter + `SWPE_CNT_ONE;
        end
    end

    assign time_base_counter_low = time_base_counter[7:0];
    assign time_base_counter_high = time_base_counter[15:8];

    // ----------------------------------------
    // buffered compare values
    // ----------------------------------------
    always_ff @(posedge clk) begin
        if (!resetn) begin
            period_shadow <= `SWPE_CMP_RESET;
            phase_shadow <= `SWPE_CNT_ZERO;
            duty_shadow <= `SWPE_CNT_ZERO;
        end else if (wr_en) begin
            unique case (wr_sel)
                swpe_pkg::SWPE_WR_PERIOD_LOW: period_shadow[7:0] <= wr_data;
                swpe_pkg::SWPE_WR_PERIOD_HIGH: period_shadow[15:8] <= wr_data;
                swpe_pkg::SWPE_WR_PHASE_LOW: phase_shadow[7:0] <= wr_data;
                swpe_pkg::SWPE_WR_PHASE_HIGH: phase_shadow[15:8] <= wr_data;
                swpe_pkg::SWPE_WR_DUTY_LOW: duty_shadow[7:0] <= wr_data;
                swpe_pkg::SWPE_WR_DUTY_HIGH: duty_shadow[15:8] <= wr_data;
                default: period_shadow <= period_shadow;
            endcase
        end
    end

    // request in the load cycle stays pending for the next period
    always_ff @(posedge clk) begin
        if (!resetn) begin
            load_pending <= 1'b0;
        end else if (buffered_load_request) begin
            load_pending <= 1'b1;
        end else if (period_event) begin
            load_pending <= 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            period_value <= `SWPE_CMP_RESET;
            phase_value <= `SWPE_CNT_ZERO;
            duty_value <= `SWPE_CNT_ZERO;
        end else if (period_event && load_pending) begin
            period_value <= period_shadow;
            phase_value <= phase_shadow;
            duty_value <= duty_shadow;
        end
    end

    // ----------------------------------------
    // event flags
    // ----------------------------------------
    assign flag_set[`SWPE_FLAG_OVF] = module_enable && !period_event
                                      && time_base_counter == `SWPE_CNT_MAX;
    assign flag_set[`SWPE_FLAG_PR] = module_enable && pr_match;
    assign flag_set[`SWPE_FLAG_PH] = module_enable && ph_match;
    assign flag_set[`SWPE_FLAG_DC] = module_enable && dc_match;

    genvar gi;
    generate
        for (gi = 0; gi < `SWPE_NFLAG; gi++) begin : g_flag
            always_ff @(posedge clk) begin
                if (!resetn || !module_enable) begin
                    flags[gi] <= 1'b0;
                end else if (flag_set[gi]) begin
                    flags[gi] <= 1'b1;
                end else if (flag_clear[gi]) begin
                    flags[gi] <= 1'b0;
                end
            end
        end
    endgenerate

    assign counter_overflow_flag = flags[`SWPE_FLAG_OVF];
    assign period_match_flag = flags[`SWPE_FLAG_PR];
    assign phase_match_flag = flags[`SWPE_FLAG_PH];
    assign duty_match_flag = flags[`SWPE_FLAG_DC];

    // summary survives disable, only an explicit clear drops it
    always_ff @(posedge clk) begin
        if (!resetn) begin
            time_base_summary_flag <= 1'b0;
        end else if (|(flag_set & irq_enable)) begin
            time_base_summary_flag <= 1'b1;
        end else if (summary_clear) begin
            time_base_summary_flag <= 1'b0;
        end
    end

    // ----------------------------------------
    // assertions
    // ----------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);

    sequence s_period_reset;
        period_event ##1 (time_base_counter == `SWPE_CNT_ZERO);
    endsequence

    sequence s_quiet_cycle;
        module_enable && !period_event;
    endsequence

    property p_period_clear;
        period_event && module_enable |-> s_period_reset;
    endproperty
    a_period_clear: assert property (p_period_clear) else $error("counter not cleared");

    property p_resume;
        s_period_reset ##0 s_quiet_cycle |=> time_base_counter == `SWPE_CNT_ONE;
    endproperty
    a_resume: assert property (p_resume) else $error("counter did not resume");

    property p_rise_once;
        rising_accepted |=> !rising_accepted throughout (!period_event [*2]);
    endproperty
    a_rise_once: assert property (p_rise_once) else $error("second rising accepted");

    property p_fall_blocks;
        fall_done |-> !rising_accepted;
    endproperty
    a_fall_blocks: assert property (p_fall_blocks) else $error("rise after fall");

    property p_sync_period;
        module_enable && period_source_select[`SWPE_SRC_TMR] && pr_match |-> period_event;
    endproperty
    a_sync_period: assert property (p_sync_period) else $error("match missed");

    property p_overflow;
        module_enable && !period_event && time_base_counter == `SWPE_CNT_MAX
            |=> counter_overflow_flag && time_base_counter == `SWPE_CNT_ZERO;
    endproperty
    a_overflow: assert property (p_overflow) else $error("overflow flag missing");

    property p_disabled;
        !module_enable |=> time_base_counter == `SWPE_CNT_ZERO && flags == `SWPE_FLAGS_ZERO
                           && !pwm_active;
    endproperty
    a_disabled: assert property (p_disabled) else $error("disable not honoured");

    property p_load;
        period_event && load_pending |=> period_value == $past(period_shadow)
                                         && duty_value == $past(duty_shadow);
    endproperty
    a_load: assert property (p_load) else $error("buffered load wrong");

    property p_hold;
        !(period_event && load_pending) |=> $stable(period_value);
    endproperty
    a_hold: assert property (p_hold) else $error("period changed early");

    property p_rise_out;
        rising_accepted && !falling_accepted |=> pwm_active;
    endproperty
    a_rise_out: assert property (p_rise_out) else $error("rise not applied");

    property p_fall_out;
        falling_accepted |=> !pwm_active && !pwm_drive;
    endproperty
    a_fall_out: assert property (p_fall_out) else $error("fall not applied");

    property p_shutdown;
        auto_shutdown |=> !pwm_drive;
    endproperty
    a_shutdown: assert property (p_shutdown) else $error("drive during shutdown");

endmodule // swpe_time_base

`default_nettype wire

// File: swpe_time_base_tb_top.sv
`timescale 1ns/1ns
`default_nettype none
`include "swpe_defines.svh"

`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin n_mismatch++; \
    $display("Error t=%0t got %h exp %h", $time, (a), (b)); end end

module swpe_time_base_tb_top;
    logic clk, resetn, module_enable, buffered_load_request, wr_en, shutdown_ext_select;
    logic shutdown_clear, modulation_reg_bit, modulation_ccp, modulation_pin, summary_clear;
    swpe_pkg::swpe_wsel_t wr_sel;
    swpe_pkg::swpe_mod_t modulation_select;
    logic [7:0] wr_data, cnt_lo, cnt_hi;
    logic [5:0] period_source_select, rising_source_select, falling_source_select;
    logic [3:0] shutdown_source_select, irq_enable, flag_clear, comp;
    logic [4:0] far_cmd;
    logic ext, load_pending, ovf, prf, phf, dcf, sumf, period_event, rising_accepted;
    logic falling_accepted, pwm_active, pwm_drive, auto_shutdown;
    logic [15:0] cnt;
    int n_mismatch = 0;
    int num_checks = 0;
    int cycles = 0;
    int r, f, p, i;

    assign cnt = {cnt_hi, cnt_lo};

    swpe_far_model far (.clk(clk), .resetn(resetn), .level_cmd(far_cmd),
        .external_event_input(ext), .comp_level(comp));

    swpe_time_base dut (.clk(clk), .resetn(resetn), .module_enable(module_enable),
        .buffered_load_request(buffered_load_request), .wr_en(wr_en), .wr_sel(wr_sel),
        .wr_data(wr_data), .period_source_select(period_source_select),
        .rising_source_select(rising_source_select),
        .falling_source_select(falling_source_select),
        .shutdown_source_select(shutdown_source_select),
        .shutdown_ext_select(shutdown_ext_select), .shutdown_clear(shutdown_clear),
        .external_event_input(ext), .comparator_one_synced(comp[0]),
        .comparator_two_synced(comp[1]), .comparator_three_synced(comp[2]),
        .comparator_four_synced(comp[3]), .modulation_select(modulation_select),
        .modulation_reg_bit(modulation_reg_bit), .modulation_ccp(modulation_ccp),
        .modulation_pin(modulation_pin), .irq_enable(irq_enable), .flag_clear(flag_clear),
        .summary_clear(summary_clear), .time_base_counter_low(cnt_lo),
        .time_base_counter_high(cnt_hi), .load_pending(load_pending),
        .counter_overflow_flag(ovf), .period_match_flag(prf), .phase_match_flag(phf),
        .duty_match_flag(dcf), .time_base_summary_flag(sumf), .period_event(period_event),
        .rising_accepted(rising_accepted), .falling_accepted(falling_accepted),
        .pwm_active(pwm_active), .pwm_drive(pwm_drive), .auto_shutdown(auto_shutdown));

    // ----------------------------------------
    // clock and timeout
    // ----------------------------------------
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // overflow scenario alone needs about 65600 cycles
    always @(posedge clk) begin
        cycles++;
        if (cycles == 90000) begin
            n_mismatch++;
            end_sim();
        end
    end

    // ----------------------------------------
    // shared tasks
    // ----------------------------------------
    task automatic end_sim();
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    task automatic wr(input swpe_pkg::swpe_wsel_t s, input logic [7:0] d);
        @(posedge clk);
        wr_en <= 1'b1;
        wr_sel <= s;
        wr_data <= d;
        @(posedge clk);
        wr_en <= 1'b0;
    endtask

    function automatic logic pick(input int w);
        case (w)
            0: pick = period_event;
            1: pick = rising_accepted;
            default: pick = falling_accepted;
        endcase
    endfunction

    // bounded wait, ends on the negedge where the pulse stands
    task automatic wait_for(input int w);
        @(negedge clk);
        for (i = 0; i < 300 && pick(w) !== 1'b1; i++) @(negedge clk);
        `CHK(pick(w), 1'b1)
    endtask

    task automatic hits(input int n);
        r = 0;
        f = 0;
        p = 0;
        repeat (n) begin
            @(negedge clk);
            r += (rising_accepted === 1'b1);
            f += (falling_accepted === 1'b1);
            p += (period_event === 1'b1);
        end
    endtask

    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic t_sync_cycle();
        @(posedge clk);
        module_enable <= 1'b1;
        period_source_select <= 6'h03;
        rising_source_select <= 6'h01;
        falling_source_select <= 6'h01;
        wr(swpe_pkg::SWPE_WR_PERIOD_LOW, 8'h05);
        wr(swpe_pkg::SWPE_WR_PERIOD_HIGH, 8'h00);
        wr(swpe_pkg::SWPE_WR_PHASE_LOW, 8'h02);
        wr(swpe_pkg::SWPE_WR_PHASE_HIGH, 8'h00);
        wr(swpe_pkg::SWPE_WR_DUTY_LOW, 8'h04);
        wr(swpe_pkg::SWPE_WR_DUTY_HIGH, 8'h00);
        @(posedge clk) buffered_load_request <= 1'b1;
        @(posedge clk) buffered_load_request <= 1'b0;
        @(negedge clk) `CHK(load_pending, 1'b1)
        @(posedge clk) far_cmd <= 5'h01;
        wait_for(0);
        @(negedge clk) `CHK(cnt, 16'h0000)
        `CHK(load_pending, 1'b0)
        @(negedge clk) `CHK(cnt, 16'h0001)
        far_cmd <= 5'h00;
        wait_for(1);
        `CHK(cnt, 16'h0002)
        @(negedge clk) `CHK(pwm_active, 1'b1)
        @(negedge clk) `CHK(pwm_drive, 1'b1)
        wait_for(2);
        `CHK(cnt, 16'h0004)
        @(negedge clk) `CHK(pwm_active, 1'b0)
        `CHK(period_event, 1'b1)
        `CHK(cnt, 16'h0005)
        @(negedge clk) `CHK(cnt, 16'h0000)
        `CHK(prf, 1'b1)
        `CHK(sumf, 1'b1)
    endtask

    task automatic t_suppress();
        @(posedge clk);
        period_source_select <= 6'h02;
        rising_source_select <= 6'h05;
        far_cmd <= 5'h01;
        wait_for(0);
        @(posedge clk) far_cmd <= 5'h00;
        wait_for(1);
        `CHK(cnt, 16'h0002)
        wait_for(2);
        `CHK(cnt, 16'h0004)
        @(posedge clk);
        falling_source_select <= 6'h21;
        far_cmd <= 5'h1A;
        hits(8);
        `CHK(r, 0)
        `CHK(f, 0)
        `CHK(p, 0)
    endtask

    task automatic t_overflow();
        @(posedge clk) far_cmd <= 5'h00;
        @(negedge clk) `CHK(ovf, 1'b0)
        for (i = 0; i < 70000 && cnt !== 16'hFFFF; i++) @(negedge clk);
        `CHK(cnt, 16'hFFFF)
        @(negedge clk) `CHK(cnt, 16'h0000)
        `CHK(ovf, 1'b1)
    endtask

    task automatic t_disable();
        @(posedge clk);
        module_enable <= 1'b0;
        far_cmd <= 5'h01;
        hits(4);
        `CHK(p, 0)
        `CHK(cnt, 16'h0000)
        `CHK({ovf, prf}, 2'b00)
        `CHK(sumf, 1'b1)
    endtask

    task automatic t_shutdown();
        @(posedge clk);
        module_enable <= 1'b1;
        far_cmd <= 5'h00;
        shutdown_source_select <= 4'h1;
        @(posedge clk) far_cmd <= 5'h02;
        repeat (3) @(negedge clk);
        `CHK(auto_shutdown, 1'b1)
        `CHK(pwm_drive, 1'b0)
        @(posedge clk) far_cmd <= 5'h00;
        repeat (2) @(posedge clk);
        shutdown_clear <= 1'b1;
        @(posedge clk) shutdown_clear <= 1'b0;
        @(negedge clk) `CHK(auto_shutdown, 1'b0)
    endtask

    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        resetn = 1'b0;
        {module_enable, buffered_load_request, wr_en, shutdown_ext_select} = 4'h0;
        {shutdown_clear, modulation_ccp, modulation_pin, summary_clear} = 4'h0;
        modulation_reg_bit = 1'b1;
        modulation_select = swpe_pkg::SWPE_MOD_REG_BIT;
        wr_sel = swpe_pkg::SWPE_WR_PERIOD_LOW;
        wr_data = 8'h00;
        {period_source_select, rising_source_select, falling_source_select} = 18'h0;
        shutdown_source_select = 4'h0;
        irq_enable = 4'h2;
        flag_clear = 4'h0;
        far_cmd = 5'h00;
        repeat (2) @(posedge clk);
        resetn <= 1'b1;
        @(negedge clk) `CHK(cnt, 16'h0000)
        `CHK({ovf, prf, sumf, load_pending}, 4'h0)
        t_sync_cycle();
        t_suppress();
        t_overflow();
        t_disable();
        t_shutdown();
        end_sim();
    end
endmodule // swpe_time_base_tb_top

`default_nettype wire
